// *** hw/tv_timing_controller.sv ***
`timescale 1ns/10ps
// Functional notes
// - see Pad route bit selects internal or general pads
// - see Vblank flag set each frame, write 0 clears
// - see Line flag set on target line match
// - see Scan line count includes blanking lines
// - see Three-bit code picks engine or test pattern
// - see Five-bit start delay before timing starts
// - see Blue override beats source select
// - see Size fields are value plus one
// - see Line and back porch are value plus one
// - see Frame is half total; back porch plus one
// - see Hsync lasts width plus one clocks
// - see Vsync lasts width plus one lines
// - see Active-low sync enables, reset disabled
// - see Ten-bit min and max per channel
// - see Safe period by three-bit mode
// - see Global disable returns timing to idle
// - see Enhanced channel is weighted input sum
// - see Enhanced result clamped to range
module tv_timing_controller (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire tv_timing_pkg::pixel_t de_pixel_i,
   input wire logic fifo_underflow_i,
   input wire logic [12:0] line_buf_level_i,
   output tv_timing_pkg::pixel_t pixel_o,
   output logic [3:0] sync_o,
   output logic [3:0] sync_oe_o,
   output logic irq_o,
   output logic safe_o,
   output logic consumer_link_pad_route_o,
   output logic line_buf_bypass_o
);
   import tv_timing_pkg::*;

   // ****************************************
   // Register state
   // ****************************************
   logic ack_q, g_en_q, pad_q, vb_en_q, line_en_q, vb_flag_q, line_flag_q;
   logic [11:0] target_q;
   logic [2:0] src_q;
   logic [3:0] inv_q, oe_n_q;
   logic c_en_q, blue_q, under_q, bypass_q, ce_en_q, fill_en_q;
   logic [4:0] delay_q;
   logic [11:0] src_w_q, src_h_q, sc_w_q, sc_h_q, out_w_q, out_h_q;
   logic [12:0] ht_q, vt_q, safe_num_q;
   logic [11:0] hbp_q, vbp_q, safe_line_q;
   logic [9:0] hspw_q, vspw_q;
   logic [10:0] coef_q;
   logic [2:0][9:0] cmin_q, cmax_q;
   logic [2:0] safe_mode_q;
   logic parity_q;
   timing_state_t state_q;
   logic [12:0] h_cnt_q;
   logic [11:0] v_cnt_q;
   logic [4:0] dly_cnt_q;
   logic [31:0] rdata, wword;
   logic req, wr;
   logic [9:0] widx, cidx, kidx;

   assign req = wb_cyc_i & wb_stb_i & ~ack_q & clk_en_i;
   assign wr = req & wb_we_i;
   assign widx = wb_adr_i[11:2];
   assign cidx = widx - OFF_COEF[11:2];
   assign kidx = widx - OFF_CLAMP[11:2];

   // ****************************************
   // Wishbone read mux
   // ****************************************
   always_comb
   begin
      rdata = 32'h0;
      unique case (wb_adr_i & 12'hffc)
         OFF_GLOBAL: rdata = {g_en_q, 29'h0, pad_q, 1'b0};
         OFF_IRQ:
         begin
            rdata[B_VB_EN] = vb_en_q;
            rdata[B_LINE_EN] = line_en_q;
            rdata[B_VB_FLAG] = vb_flag_q;
            rdata[B_LINE_FLAG] = line_flag_q;
         end
         OFF_TARGET: rdata[11:0] = target_q;
         OFF_SRC: rdata[2:0] = src_q;
         OFF_INV: rdata[F_SYNC+:4] = inv_q;
         OFF_OE: rdata[F_SYNC+:4] = oe_n_q;
         OFF_CTL:
         begin
            rdata[B_EN] = c_en_q;
            rdata[F_DELAY+:5] = delay_q;
            rdata[B_BLUE] = blue_q;
         end
         OFF_SRC_SIZE: rdata = {4'h0, src_w_q, 4'h0, src_h_q};
         OFF_SCALED: rdata = {4'h0, sc_w_q, 4'h0, sc_h_q};
         OFF_OUT_SIZE: rdata = {4'h0, out_w_q, 4'h0, out_h_q};
         OFF_HTIME: rdata = {3'h0, ht_q, 4'h0, hbp_q};
         OFF_VTIME: rdata = {3'h0, vt_q, 4'h0, vbp_q};
         OFF_SYNCW: rdata = {6'h0, hspw_q, 6'h0, vspw_q};
         OFF_DEBUG:
         begin
            rdata[B_UNDER] = under_q;
            rdata[B_PARITY] = parity_q;
            rdata[B_BYPASS] = bypass_q;
            rdata[11:0] = v_cnt_q;
         end
         OFF_CE_CTL: rdata[B_EN] = ce_en_q;
         OFF_SAFE:
         begin
            rdata[F_HI+:13] = safe_num_q;
            rdata[F_SAFE_LINE+:12] = safe_line_q;
            rdata[2:0] = safe_mode_q;
         end
         OFF_FILL: rdata[B_EN] = fill_en_q;
         default:
         begin
            if (cidx < COEF_COUNT)
               rdata[B_COEF] = coef_q[cidx[3:0]];
            else if (kidx < CLAMP_COUNT)
               rdata = {6'h0, cmin_q[kidx[1:0]], 6'h0, cmax_q[kidx[1:0]]};
         end
      endcase
   end

   // Unselected byte lanes keep their present contents
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         wword[i*8+:8] = wb_sel_i[i] ? wb_dat_i[i*8+:8] : rdata[i*8+:8];
   end

   // ****************************************
   // Bus answer: one cycle after request
   // ****************************************
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         ack_q <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else if (clk_en_i)
      begin
         ack_q <= req;
         if (req)
            wb_dat_o <= rdata;
      end
   end
   assign wb_ack_o = ack_q;

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         g_en_q <= 1'b0;
         pad_q <= 1'b0;
         vb_en_q <= 1'b0;
         line_en_q <= 1'b0;
         target_q <= 12'h0;
         src_q <= SRC_ENGINE;
         inv_q <= 4'h0;
         oe_n_q <= OE_N_RESET;
         c_en_q <= 1'b0;
         delay_q <= 5'h0;
         blue_q <= 1'b0;
         bypass_q <= 1'b0;
         ce_en_q <= 1'b0;
         fill_en_q <= 1'b0;
      end
      else if (wr)
      begin
         unique case (wb_adr_i & 12'hffc)
            OFF_GLOBAL:
            begin
               g_en_q <= wword[B_EN];
               pad_q <= wword[B_PAD];
            end
            OFF_IRQ:
            begin
               vb_en_q <= wword[B_VB_EN];
               line_en_q <= wword[B_LINE_EN];
            end
            OFF_TARGET:
            begin
               if (!line_en_q)
                  target_q <= wword[11:0];
            end
            OFF_SRC: src_q <= wword[2:0];
            OFF_INV: inv_q <= wword[F_SYNC+:4];
            OFF_OE: oe_n_q <= wword[F_SYNC+:4];
            OFF_CTL:
            begin
               c_en_q <= wword[B_EN];
               delay_q <= wword[F_DELAY+:5];
               blue_q <= wword[B_BLUE];
            end
            OFF_DEBUG: bypass_q <= wword[B_BYPASS];
            OFF_CE_CTL: ce_en_q <= wword[B_EN];
            OFF_FILL: fill_en_q <= wword[B_EN];
            default:
            begin
            end
         endcase
      end
   end

   // Timing and size fields stored as value minus one, except vertical total (frame is half of it) and the safe fields
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         {src_w_q, src_h_q, sc_w_q, sc_h_q, out_w_q, out_h_q} <= '0;
         {ht_q, hbp_q, vt_q, vbp_q, hspw_q, vspw_q} <= '0;
         {safe_num_q, safe_line_q, safe_mode_q} <= '0;
      end
      else if (wr)
      begin
         unique case (wb_adr_i & 12'hffc)
            OFF_SRC_SIZE: {src_w_q, src_h_q} <= {wword[F_HI+:12], wword[11:0]};
            OFF_SCALED: {sc_w_q, sc_h_q} <= {wword[F_HI+:12], wword[11:0]};
            OFF_OUT_SIZE: {out_w_q, out_h_q} <= {wword[F_HI+:12], wword[11:0]};
            OFF_HTIME: {ht_q, hbp_q} <= {wword[F_HI+:13], wword[11:0]};
            OFF_VTIME: {vt_q, vbp_q} <= {wword[F_HI+:13], wword[11:0]};
            OFF_SYNCW: {hspw_q, vspw_q} <= {wword[F_HI+:10], wword[9:0]};
            OFF_SAFE:
            begin
               safe_num_q <= wword[F_HI+:13];
               safe_line_q <= wword[F_SAFE_LINE+:12];
               safe_mode_q <= wword[2:0];
            end
            default:
            begin
            end
         endcase
      end
   end

   // Matrix coefficients and clamp limits, one generate per entry
   for (genvar n = 0; n < 11; n++)
   begin : g_coef
      always_ff @(posedge core_clk_i)
      begin
         if (reset_i)
            coef_q[n] <= 1'b0;
         else if (wr && cidx == 10'(n))
            coef_q[n] <= wword[B_COEF];
      end
   end
   for (genvar k = 0; k < 3; k++)
   begin : g_clamp
      always_ff @(posedge core_clk_i)
      begin
         if (reset_i)
         begin
            cmin_q[k] <= 10'h0;
            cmax_q[k] <= 10'h0;
         end
         else if (wr && kidx == 10'(k))
         begin
            cmin_q[k] <= wword[F_HI+:10];
            cmax_q[k] <= wword[9:0];
         end
      end
   end

   // ****************************************
   // Scan timing
   // ****************************************
   logic run, h_end, v_end, h_act, v_act, hs_raw, vs_raw, line_hit, vb_hit;
   logic [11:0] h_pix, v_pix;
   logic [11:0] frame_lines;
   assign run = state_q == T_RUN;
   assign frame_lines = vt_q[12:1];
   assign h_end = h_cnt_q >= ht_q;
   assign v_end = v_cnt_q + 12'h1 >= frame_lines;
   // Active window starts after back porch, lasts size plus one
   assign h_act = {1'b0, h_cnt_q} > {2'b0, hbp_q}
      && {1'b0, h_cnt_q} < 14'({2'b0, hbp_q} + {2'b0, out_w_q} + 14'h2);
   assign v_act = {1'b0, v_cnt_q} > {1'b0, vbp_q}
      && {1'b0, v_cnt_q} < 13'({1'b0, vbp_q} + {1'b0, out_h_q} + 13'h2);
   assign hs_raw = run && h_cnt_q <= {3'h0, hspw_q};
   assign vs_raw = run && v_cnt_q <= {2'h0, vspw_q};
   assign h_pix = 12'(h_cnt_q - {1'b0, hbp_q} - 13'h1);
   assign v_pix = v_cnt_q - vbp_q - 12'h1;
   assign line_hit = run && h_cnt_q == 13'h0 && v_cnt_q == target_q;
   assign vb_hit = run && h_cnt_q == 13'h0 && v_cnt_q == 12'h0;

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         state_q <= T_IDLE;
         dly_cnt_q <= 5'h0;
         h_cnt_q <= 13'h0;
         v_cnt_q <= 12'h0;
         parity_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (!(g_en_q && c_en_q))
         begin
            state_q <= T_IDLE;
            h_cnt_q <= 13'h0;
            v_cnt_q <= 12'h0;
            parity_q <= 1'b0;
         end
         else
         begin
            unique case (state_q)
               T_IDLE:
               begin
                  dly_cnt_q <= 5'h0;
                  state_q <= T_DELAY;
               end
               T_DELAY:
               begin
                  dly_cnt_q <= dly_cnt_q + 5'h1;
                  if (dly_cnt_q >= delay_q)
                     state_q <= T_RUN;
               end
               T_RUN:
               begin
                  h_cnt_q <= h_end ? 13'h0 : h_cnt_q + 13'h1;
                  if (h_end)
                  begin
                     v_cnt_q <= v_end ? 12'h0 : v_cnt_q + 12'h1;
                     if (v_end)
                        parity_q <= ~parity_q;
                  end
               end
            endcase
         end
      end
   end

   // ****************************************
   // Flags: hardware set wins over clear
   // ****************************************
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         vb_flag_q <= 1'b0;
         line_flag_q <= 1'b0;
         under_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (vb_hit)
            vb_flag_q <= 1'b1;
         else if (wr && wb_adr_i[11:2] == OFF_IRQ[11:2] && !wword[B_VB_FLAG])
            vb_flag_q <= 1'b0;
         if (line_hit)
            line_flag_q <= 1'b1;
         else if (wr && wb_adr_i[11:2] == OFF_IRQ[11:2] && !wword[B_LINE_FLAG])
            line_flag_q <= 1'b0;
         if (fifo_underflow_i)
            under_q <= 1'b1;
         else if (wr && wb_adr_i[11:2] == OFF_DEBUG[11:2] && !wword[B_UNDER])
            under_q <= 1'b0;
      end
   end

   // ****************************************
   // Pixel source, stage one
   // ****************************************
   pixel_t src_pix, s1_pix_q;
   logic [3:0] s1_sync_q;
   logic [2:0] bar;
   assign bar = h_pix[8:6];
   always_comb
   begin
      src_pix = '0;
      unique case (src_q)
         SRC_ENGINE: src_pix = de_pixel_i;
         SRC_COLOUR: src_pix = {{10{bar[2]}}, {10{bar[1]}}, {10{bar[0]}}};
         SRC_GRAY: src_pix = {3{h_pix[9:0]}};
         SRC_BW: src_pix = {30{h_pix[5] ^ v_pix[5]}};
         SRC_GRID: src_pix = {30{h_pix[3:0] == 4'h0 || v_pix[3:0] == 4'h0}};
         default: src_pix = '0;
      endcase
      if (blue_q)
         src_pix = {20'h0, 10'h3ff};
      if (!(run && h_act && v_act))
         src_pix = '0;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         s1_pix_q <= '0;
         s1_sync_q <= 4'h0;
      end
      else if (clk_en_i)
      begin
         s1_pix_q <= src_pix;
         s1_sync_q <= {run && !v_act, run && h_act && v_act, vs_raw, hs_raw};
      end
   end

   // ****************************************
   // Colour matrix and clamp, stage two
   // ****************************************
   // Index 2 is red, 1 green, 0 blue; coefficients 0/1 need no multiplier
   logic [2:0][9:0] in_ch, out_ch;
   assign in_ch = s1_pix_q;
   for (genvar k = 0; k < 3; k++)
   begin : g_ceu
      localparam int BASE = (2 - k) * 4;
      logic [11:0] sum;
      assign sum = (coef_q[BASE] ? {2'h0, in_ch[2]} : 12'h0)
         + (coef_q[BASE+1] ? {2'h0, in_ch[1]} : 12'h0)
         + (coef_q[BASE+2] ? {2'h0, in_ch[0]} : 12'h0);
      always_comb
      begin
         if (!ce_en_q)
            out_ch[k] = in_ch[k];
         else if (sum < {2'h0, cmin_q[2-k]})
            out_ch[k] = cmin_q[2-k];
         else if (sum > {2'h0, cmax_q[2-k]})
            out_ch[k] = cmax_q[2-k];
         else
            out_ch[k] = sum[9:0];
      end
   end

   // ****************************************
   // Output flops
   // ****************************************
   logic safe_d;
   always_comb
   begin
      unique case (safe_mode_q)
         SAFE_NEVER: safe_d = 1'b0;
         SAFE_ALWAYS: safe_d = 1'b1;
         SAFE_FIFO: safe_d = line_buf_level_i > safe_num_q;
         SAFE_SYNC: safe_d = hs_raw || vs_raw;
         SAFE_LINE: safe_d = run && v_cnt_q == safe_line_q;
         default: safe_d = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         pixel_o <= '0;
         sync_o <= 4'h0;
         sync_oe_o <= 4'h0;
         irq_o <= 1'b0;
         safe_o <= 1'b0;
         consumer_link_pad_route_o <= 1'b0;
         line_buf_bypass_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         pixel_o <= out_ch;
         sync_o <= s1_sync_q ^ inv_q;
         sync_oe_o <= ~oe_n_q;
         irq_o <= (vb_flag_q && vb_en_q) || (line_flag_q && line_en_q);
         safe_o <= safe_d;
         consumer_link_pad_route_o <= pad_q;
         line_buf_bypass_o <= bypass_q;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   a_ack_single: assert property (clk_en_i && ack_q |=> !ack_q)
      else $error("ack held more than one cycle");
   a_line_flag: assert property (clk_en_i && line_hit |=> line_flag_q)
      else $error("line match did not set flag");
   a_vb_flag: assert property (clk_en_i && vb_hit |=> vb_flag_q)
      else $error("frame start did not set vblank flag");
   a_target_lock: assert property (line_en_q |=> $stable(target_q))
      else $error("target line changed while trigger enabled");
   a_idle_disable: assert property (clk_en_i && !g_en_q |=> state_q == T_IDLE)
      else $error("timing not idle after global disable");
   a_line_wrap: assert property (clk_en_i && run && h_end && g_en_q && c_en_q
      |=> h_cnt_q == 13'h0)
      else $error("line did not wrap at horizontal total");
   a_clamp_range: assert property (clk_en_i && ce_en_q && cmin_q[0] <= cmax_q[0]
      |=> pixel_o.r >= $past(cmin_q[0]) && pixel_o.r <= $past(cmax_q[0]))
      else $error("red channel outside clamp range");
   a_blue_force: assert property (clk_en_i && blue_q && run && h_act && v_act
      |=> s1_pix_q == {20'h0, 10'h3ff})
      else $error("blue override not applied");
   a_irq_follow: assert property (clk_en_i && vb_flag_q && vb_en_q |=> irq_o)
      else $error("interrupt not raised for enabled flag");

   c_line_hit: cover property (line_hit ##1 line_flag_q);
   c_frame_wrap: cover property (run && h_end && v_end);
   c_bus_write: cover property (wr ##1 ack_q);
   c_irq: cover property (irq_o);
endmodule

// *** hw/tv_timing_pkg.sv ***
package tv_timing_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [11:0] OFF_GLOBAL = 12'h000;
   localparam logic [11:0] OFF_IRQ = 12'h004;
   localparam logic [11:0] OFF_TARGET = 12'h008;
   localparam logic [11:0] OFF_SRC = 12'h040;
   localparam logic [11:0] OFF_INV = 12'h088;
   localparam logic [11:0] OFF_OE = 12'h08c;
   localparam logic [11:0] OFF_CTL = 12'h090;
   localparam logic [11:0] OFF_SRC_SIZE = 12'h094;
   localparam logic [11:0] OFF_SCALED = 12'h098;
   localparam logic [11:0] OFF_OUT_SIZE = 12'h09c;
   localparam logic [11:0] OFF_HTIME = 12'h0a0;
   localparam logic [11:0] OFF_VTIME = 12'h0a4;
   localparam logic [11:0] OFF_SYNCW = 12'h0a8;
   localparam logic [11:0] OFF_DEBUG = 12'h0fc;
   localparam logic [11:0] OFF_CE_CTL = 12'h100;
   localparam logic [11:0] OFF_COEF = 12'h110;
   localparam logic [11:0] OFF_CLAMP = 12'h140;
   localparam logic [11:0] OFF_SAFE = 12'h1f0;
   localparam logic [11:0] OFF_FILL = 12'h300;
   localparam logic [9:0] COEF_COUNT = 10'h00b;
   localparam logic [9:0] CLAMP_COUNT = 10'h003;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int F_HI = 16;
   localparam int B_EN = 31;
   localparam int B_PAD = 1;
   localparam int B_VB_EN = 30;
   localparam int B_LINE_EN = 28;
   localparam int B_VB_FLAG = 14;
   localparam int B_LINE_FLAG = 12;
   localparam int B_BLUE = 1;
   localparam int F_DELAY = 4;
   localparam int F_SYNC = 24;
   localparam int B_UNDER = 30;
   localparam int B_PARITY = 28;
   localparam int B_BYPASS = 13;
   localparam int B_COEF = 8;
   localparam int F_SAFE_LINE = 4;
   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [3:0] OE_N_RESET = 4'hf;
   localparam logic [2:0] SRC_ENGINE = 3'h0;
   localparam logic [2:0] SRC_COLOUR = 3'h1;
   localparam logic [2:0] SRC_GRAY = 3'h2;
   localparam logic [2:0] SRC_BW = 3'h3;
   localparam logic [2:0] SRC_GRID = 3'h7;
   localparam logic [2:0] SAFE_NEVER = 3'h0;
   localparam logic [2:0] SAFE_ALWAYS = 3'h1;
   localparam logic [2:0] SAFE_FIFO = 3'h2;
   localparam logic [2:0] SAFE_SYNC = 3'h3;
   localparam logic [2:0] SAFE_LINE = 3'h4;
   typedef struct packed {
      logic [9:0] r;
      logic [9:0] g;
      logic [9:0] b;
   } pixel_t;
   typedef enum logic [1:0] {T_IDLE, T_DELAY, T_RUN} timing_state_t;
endpackage

// *** dv/tv_panel_model.sv ***
`timescale 1ns/10ps
// ****************************************
// Panel side: measures sync pulse widths
// ****************************************
module tv_panel_model (
   input wire logic core_clk_i,
   input wire logic [3:0] sync_i,
   output int hs_width_o,
   output int line_len_o,
   output int vs_width_o
);
   int hs_cnt = 0;
   int vs_cnt = 0;
   int line_cnt = 0;
   logic seen_q = 1'b0;
   initial
   begin
      hs_width_o = 0;
      line_len_o = 0;
      vs_width_o = 0;
   end
   // Only a pulse with a seen rising edge is measured; idle low is no pulse
   always @(posedge core_clk_i)
   begin
      hs_cnt <= sync_i[0] ? hs_cnt + 1 : 0;
      vs_cnt <= sync_i[1] ? vs_cnt + 1 : 0;
      line_cnt <= line_cnt + 1;
      if (!sync_i[0] && hs_cnt != 0)
         hs_width_o <= hs_cnt;
      if (!sync_i[1] && vs_cnt != 0)
         vs_width_o <= vs_cnt;
      if (sync_i[0] && hs_cnt == 0)
      begin
         seen_q <= 1'b1;
         line_cnt <= 1;
         if (seen_q)
            line_len_o <= line_cnt;
      end
   end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import tv_timing_pkg::*;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   pixel_t pixel_o;
   logic [3:0] sync_o;
   logic [3:0] sync_oe_o;
   logic irq_o;
   logic safe_o;
   logic pad_route;
   logic bypass;
   logic [31:0] rd;
   int hs_w;
   int line_len;
   int vs_w;
   int error_cnt = 0;
   int tests_run = 0;
   pixel_t de_pix = {10'h100, 10'h020, 10'h003};
   logic under = 1'b0;
   logic [12:0] level = 13'h000;
   always #5 core_clk_i = ~core_clk_i;
   tv_timing_controller dut (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .de_pixel_i(de_pix),
      .fifo_underflow_i(under), .line_buf_level_i(level), .pixel_o(pixel_o),
      .sync_o(sync_o), .sync_oe_o(sync_oe_o), .irq_o(irq_o), .safe_o(safe_o),
      .consumer_link_pad_route_o(pad_route), .line_buf_bypass_o(bypass));
   tv_panel_model panel (
      .core_clk_i(core_clk_i), .sync_i(sync_o),
      .hs_width_o(hs_w), .line_len_o(line_len), .vs_width_o(vs_w));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled high
   task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20)
      begin
         error_cnt++;
         $display("ERROR t=%0t bus timeout", $time);
         tally_and_finish();
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   // Data-active sync bit and pixel_o leave the same output flop stage
   task automatic wait_active();
      int n;
      n = 0;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (sync_o[2] !== 1'b1 && n < 500);
      if (n >= 500)
      begin
         error_cnt++;
         $display("ERROR t=%0t no active pixel", $time);
         tally_and_finish();
      end
   endtask
   task automatic t_reset_and_pins();
      bus(1'b0, OFF_OE, 32'h0);
      check(rd, 32'h0f00_0000);
      check(sync_oe_o, 4'h0);
      bus(1'b1, OFF_OE, 32'h0);
      bus(1'b1, OFF_GLOBAL, 32'h0000_0002);
      bus(1'b1, OFF_DEBUG, 32'h0000_2000);
      bus(1'b0, 12'h010, 32'h0);
      check(rd, 32'h0);
      check(sync_oe_o, 4'hf);
      check(pad_route, 1'b1);
      check(bypass, 1'b1);
      bus(1'b1, OFF_SRC_SIZE, 32'h0013_0009);
      bus(1'b1, OFF_SCALED, 32'h0009_0009);
      bus(1'b0, OFF_SCALED, 32'h0);
      check(rd, 32'h0009_0009);
      $display("test reset_and_pins done");
   endtask
   task automatic t_timing();
      int n;
      bus(1'b1, OFF_TARGET, 32'h0000_0002);
      bus(1'b1, OFF_IRQ, 32'h5000_0000);
      bus(1'b1, OFF_TARGET, 32'h0000_0005);
      bus(1'b0, OFF_TARGET, 32'h0);
      check(rd, 32'h0000_0002);
      bus(1'b1, OFF_HTIME, 32'h0013_0002);
      bus(1'b1, OFF_VTIME, 32'h0014_0001);
      bus(1'b1, OFF_SYNCW, 32'h0003_0001);
      bus(1'b1, OFF_CTL, 32'h8000_0000);
      bus(1'b1, OFF_GLOBAL, 32'h8000_0002);
      n = 0;
      // Two frames so a line period and a whole vsync are both measured
      while (line_len == 0 || vs_w == 0 || n < 400)
      begin
         @(posedge core_clk_i);
         n++;
         if (n > 2000)
         begin
            error_cnt++;
            $display("ERROR t=%0t no sync seen", $time);
            tally_and_finish();
         end
      end
      check(line_len, 20);
      check(hs_w, 4);
      check(vs_w, 40);
      bus(1'b0, OFF_IRQ, 32'h0);
      check(rd, 32'h5000_5000);
      check(irq_o, 1'b1);
      $display("test timing done");
   endtask
   // Red takes R plus G; engine pixel is r 100, g 020, b 003
   task automatic t_pixel_path();
      bus(1'b1, OFF_CLAMP, 32'h0000_03ff);
      bus(1'b1, OFF_COEF, 32'h0000_0100);
      bus(1'b1, OFF_COEF + 12'h004, 32'h0000_0100);
      bus(1'b1, OFF_CE_CTL, 32'h8000_0000);
      wait_active();
      check(pixel_o.r, 10'h120);
      check(pixel_o.b, 10'h000);
      bus(1'b1, OFF_CLAMP, 32'h0000_00ff);
      wait_active();
      check(pixel_o.r, 10'h0ff);
      bus(1'b1, OFF_CLAMP, 32'h0200_03ff);
      bus(1'b0, OFF_CLAMP, 32'h0);
      check(rd, 32'h0200_03ff);
      wait_active();
      check(pixel_o.r, 10'h200);
      $display("test pixel_path done");
   endtask
   task automatic t_safe_status();
      bus(1'b1, OFF_SAFE, 32'h0005_0002);
      level <= 13'h006;
      repeat (2) @(posedge core_clk_i);
      check(safe_o, 1'b1);
      level <= 13'h005;
      repeat (2) @(posedge core_clk_i);
      check(safe_o, 1'b0);
      bus(1'b1, OFF_SAFE, 32'h0000_0001);
      @(posedge core_clk_i);
      check(safe_o, 1'b1);
      under <= 1'b1;
      @(posedge core_clk_i);
      under <= 1'b0;
      bus(1'b0, OFF_DEBUG, 32'h0);
      check(rd[B_UNDER], 1'b1);
      bus(1'b1, OFF_DEBUG, 32'h0000_2000);
      bus(1'b0, OFF_DEBUG, 32'h0);
      check(rd[B_UNDER], 1'b0);
      $display("test safe_status done");
   endtask
   task automatic t_disable_and_clear();
      bus(1'b1, OFF_GLOBAL, 32'h0);
      bus(1'b0, OFF_DEBUG, 32'h0);
      check(rd[11:0], 12'h000);
      bus(1'b1, OFF_IRQ, 32'h0);
      bus(1'b0, OFF_IRQ, 32'h0);
      check(rd, 32'h0);
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      check(irq_o, 1'b0);
      check(sync_o, 4'h0);
      $display("test disable_and_clear done");
   endtask
   initial
   begin
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      t_reset_and_pins();
      t_timing();
      t_pixel_path();
      t_safe_status();
      t_disable_and_clear();
      tally_and_finish();
   end
endmodule
